//--- design/timer0_defs.vh
// Register map, field positions, reset values and timing counts of the timer block.
`ifndef TIMER0_DEFS_VH
`define TIMER0_DEFS_VH

// Word indexes as printed; byte address is four times the index.
`define TMR_COUNT_IDX 10'h001
`define INT_CTRL_IDX 10'h00B
`define OPT_CFG_IDX 10'h081
`define IRQ_STATUS_IDX 10'h0C0
`define IRQ_MASK_IDX 10'h0C1
`define WDT_CMD_IDX 10'h0C2

// Field positions of option_config.
`define OPT_SRC_BIT 5
`define OPT_EDGE_BIT 4
`define OPT_PSA_BIT 3
`define OPT_RATE_HI 2
`define OPT_RATE_LO 0

// Field positions of interrupt_control.
`define INT_OVF_EN_BIT 5
`define INT_OVF_FLAG_BIT 2

// Event bits of the status and mask registers.
`define EVT_OVF_BIT 0
`define EVT_WDT_BIT 1
`define EVT_WIDTH 2

// Command register bit that stands for the watchdog-clear instruction.
`define WDT_CMD_CLR_BIT 0

// Reset values.
`define OPT_CFG_RST 8'hFF
`define INT_CTRL_RST 8'h00
`define TMR_COUNT_RST 8'h00

// Instruction cycles of increment suppression after a count write.
`define WR_INHIBIT_CYC 2'h2

// AHB transfer type and response codes.
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HRESP_OKAY 1'h0

`endif

//--- design/prescale_counter.v
// Shared 8-bit prescale counter with synchronous clear.
`timescale 1ns/100ps
module prescale_counter (
    // Clock, reset and enable.
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // Control.
    input wire inc,
    input wire clr,
    // State.
    output reg [7:0] count_r
);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= 8'h00;
        end else if (ce) begin
            // Clear wins over a count in the same cycle.
            if (clr) begin
                count_r <= 8'h00;
            end else if (inc) begin
                count_r <= count_r + 8'h01;
            end
        end
    end

endmodule

//--- design/timer0_shared_prescaler.v
// Timer/counter with a prescaler shared with the watchdog, behind an AHB-Lite slave.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "timer0_defs.vh"

module timer0_shared_prescaler (
    // Clock, reset and enable.
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // AHB-Lite slave.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // External count pin.
    input wire timer_ext_clock_pin,
    // Watchdog side.
    input wire watchdog_timer_base_tick,
    output reg watchdog_timer_tick_r,
    output reg watchdog_clear_instr_r,
    // Interrupt.
    output wire irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction-cycle phases.

    localparam [3:0] PH_ONE = 4'h1;
    localparam [3:0] PH_TWO = 4'h2;
    localparam [3:0] PH_THREE = 4'h4;
    localparam [3:0] PH_FOUR = 4'h8;

    reg [3:0] phase_r;
    reg [3:0] phase_nxt;

    always @* begin
        case (phase_r)
            PH_ONE: begin
                phase_nxt = PH_TWO;
            end
            PH_TWO: begin
                phase_nxt = PH_THREE;
            end
            PH_THREE: begin
                phase_nxt = PH_FOUR;
            end
            PH_FOUR: begin
                phase_nxt = PH_ONE;
            end
            default: begin
                phase_nxt = PH_ONE;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= PH_ONE;
        end else if (ce) begin
            phase_r <= phase_nxt;
        end
    end

    wire phase_two = (phase_r == PH_TWO);
    wire phase_four = (phase_r == PH_FOUR);
    wire instr_tick = phase_four;

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Mask of the low rate bits; all ones in them marks a prescaled watchdog tick.
    function [7:0] rate_mask;
        input [2:0] rate;
        begin
            rate_mask = (8'h01 << rate) - 8'h01;
        end
    endfunction

    // Word index of an AHB byte address.
    function [9:0] word_idx;
        input [31:0] addr;
        begin
            word_idx = addr[11:2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    reg [7:0] tmr_count_r;
    reg [7:0] tmr_count_nxt;
    reg [7:0] int_ctrl_r;
    reg [7:0] int_ctrl_nxt;
    reg [7:0] opt_cfg_r;
    reg [`EVT_WIDTH-1:0] irq_status_r;
    reg [`EVT_WIDTH-1:0] irq_status_nxt;
    reg [`EVT_WIDTH-1:0] irq_mask_r;
    reg [1:0] inhibit_r;
    reg [1:0] inhibit_nxt;

    wire timer_source_sel = opt_cfg_r[`OPT_SRC_BIT];
    wire ext_edge_sel = opt_cfg_r[`OPT_EDGE_BIT];
    wire prescaler_assign_sel = opt_cfg_r[`OPT_PSA_BIT];
    wire [2:0] prescale_rate_sel = opt_cfg_r[`OPT_RATE_HI:`OPT_RATE_LO];

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, writes land at the end of the data phase.

    reg wr_pend_r;
    reg [9:0] wr_idx_r;

    wire ahb_act = hsel & hready & (htrans == `HTRANS_NONSEQ | htrans == `HTRANS_SEQ);
    wire ahb_wr = ahb_act & hwrite;
    wire ahb_rd = ahb_act & ~hwrite;
    wire [9:0] rd_idx = word_idx(haddr);

    assign hreadyout = 1'b1;
    assign hresp = `HRESP_OKAY;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 10'h000;
        end else if (ce) begin
            wr_pend_r <= ahb_wr;
            wr_idx_r <= rd_idx;
        end
    end

    wire wr_tmr = wr_pend_r & (wr_idx_r == `TMR_COUNT_IDX);
    wire wr_int = wr_pend_r & (wr_idx_r == `INT_CTRL_IDX);
    wire wr_opt = wr_pend_r & (wr_idx_r == `OPT_CFG_IDX);
    wire wr_sts = wr_pend_r & (wr_idx_r == `IRQ_STATUS_IDX);
    wire wr_msk = wr_pend_r & (wr_idx_r == `IRQ_MASK_IDX);
    wire wr_cmd = wr_pend_r & (wr_idx_r == `WDT_CMD_IDX);
    wire wdt_clear = wr_cmd & hwdata[`WDT_CMD_CLR_BIT];

    // Read data is registered in the address phase; unmapped words read zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ce && ahb_rd) begin
            case (rd_idx)
                `TMR_COUNT_IDX: begin
                    hrdata <= {24'h000000, tmr_count_r};
                end
                `INT_CTRL_IDX: begin
                    hrdata <= {24'h000000, int_ctrl_r};
                end
                `OPT_CFG_IDX: begin
                    hrdata <= {24'h000000, opt_cfg_r};
                end
                `IRQ_STATUS_IDX: begin
                    hrdata <= {30'h0, irq_status_r};
                end
                `IRQ_MASK_IDX: begin
                    hrdata <= {30'h0, irq_mask_r};
                end
                default: begin
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge selection.

    reg pin_meta_r;
    reg pin_sync_r;
    reg pin_lvl_prev_r;

    // Inverting the pin turns falling edges into rising ones.
    wire pin_lvl = pin_sync_r ^ ext_edge_sel;
    wire pin_edge = pin_lvl & ~pin_lvl_prev_r;

    // The previous level starts high because a low pin with the reset edge bit reads high.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_lvl_prev_r <= 1'b1;
        end else if (ce) begin
            pin_meta_r <= timer_ext_clock_pin;
            pin_sync_r <= pin_meta_r;
            pin_lvl_prev_r <= pin_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared prescaler.

    wire [7:0] pre_count;
    wire pre_inc;
    wire pre_clr;

    // The prescaler follows the timer source or the watchdog base, never both.
    assign pre_inc = prescaler_assign_sel ? watchdog_timer_base_tick
                   : (timer_source_sel ? pin_edge : instr_tick);
    assign pre_clr = (wr_tmr & ~prescaler_assign_sel)
                   | (wdt_clear & prescaler_assign_sel);

    prescale_counter u_prescale (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .inc(pre_inc),
        .clr(pre_clr),
        .count_r(pre_count)
    );

    // Bit n of the count rises once every 2^(n+1) input events.
    wire pre_out_lvl = prescaler_assign_sel ? pin_lvl
                     : pre_count[prescale_rate_sel];

    // Watchdog tick: every base tick unprescaled, else once per 2^rate ticks.
    wire [7:0] wdt_mask = rate_mask(prescale_rate_sel);
    wire wdt_tick = watchdog_timer_base_tick
                  & (~prescaler_assign_sel
                  | ((pre_count & wdt_mask) == wdt_mask));

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_timer_tick_r <= 1'b0;
            watchdog_clear_instr_r <= 1'b0;
        end else if (ce) begin
            watchdog_timer_tick_r <= wdt_tick;
            watchdog_clear_instr_r <= wdt_clear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase sampling of the prescaler output.

    reg samp_two_r;
    reg samp_four_r;

    // Both samples start high, the reset level of the source, so reset makes no count.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_two_r <= 1'b1;
            samp_four_r <= 1'b1;
        end else if (ce) begin
            if (phase_two) begin
                samp_two_r <= pre_out_lvl;
            end
            if (phase_four) begin
                samp_four_r <= pre_out_lvl;
            end
        end
    end

    // A rise before the phase-two sample or before the phase-four one counts once.
    wire sampled_event = phase_four & ((samp_two_r & ~samp_four_r)
                       | (pre_out_lvl & ~samp_two_r));

    // Plain timer mode without prescaler needs no sampling: it ticks once per instruction cycle.
    wire use_sampled = timer_source_sel | ~prescaler_assign_sel;
    wire count_event = use_sampled ? sampled_event : instr_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter, write inhibit and overflow.

    wire inc_ok = count_event & (inhibit_r == 2'h0);
    wire overflow = inc_ok & ~wr_tmr & (tmr_count_r == 8'hFF);

    always @* begin
        inhibit_nxt = inhibit_r;
        if (wr_tmr) begin
            inhibit_nxt = `WR_INHIBIT_CYC;
        end else if (instr_tick && inhibit_r != 2'h0) begin
            inhibit_nxt = inhibit_r - 2'h1;
        end
    end

    always @* begin
        tmr_count_nxt = tmr_count_r;
        // A software write beats an increment in the same cycle.
        if (wr_tmr) begin
            tmr_count_nxt = hwdata[7:0];
        end else if (inc_ok) begin
            tmr_count_nxt = tmr_count_r + 8'h01;
        end
    end

    always @* begin
        int_ctrl_nxt = int_ctrl_r;
        if (wr_int) begin
            int_ctrl_nxt = hwdata[7:0];
        end
        if (overflow) begin
            int_ctrl_nxt[`INT_OVF_FLAG_BIT] = 1'b1;
        end
    end

    always @* begin
        irq_status_nxt = irq_status_r;
        if (wr_sts) begin
            irq_status_nxt = irq_status_r & ~hwdata[`EVT_WIDTH-1:0];
        end
        // Setting wins over a write-one clear in the same cycle.
        if (overflow) begin
            irq_status_nxt[`EVT_OVF_BIT] = 1'b1;
        end
        if (wdt_tick) begin
            irq_status_nxt[`EVT_WDT_BIT] = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_count_r <= `TMR_COUNT_RST;
            int_ctrl_r <= `INT_CTRL_RST;
            opt_cfg_r <= `OPT_CFG_RST;
            irq_status_r <= {`EVT_WIDTH{1'b0}};
            irq_mask_r <= {`EVT_WIDTH{1'b0}};
            inhibit_r <= 2'h0;
        end else if (ce) begin
            tmr_count_r <= tmr_count_nxt;
            int_ctrl_r <= int_ctrl_nxt;
            irq_status_r <= irq_status_nxt;
            inhibit_r <= inhibit_nxt;
            // Only an option write moves the assignment; a count write never does.
            if (wr_opt) begin
                opt_cfg_r <= hwdata[7:0];
            end
            if (wr_msk) begin
                irq_mask_r <= hwdata[`EVT_WIDTH-1:0];
            end
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

endmodule

//--- sim/timer0_checker.sv
// Checker for the timer block's bus answers, pulses and read data.
`timescale 1ns/100ps
`include "timer0_defs.vh"
module timer0_checker (
    // Clock, reset and enable.
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // Bus.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Watchdog side.
    input wire watchdog_timer_base_tick,
    input wire watchdog_timer_tick_r,
    input wire watchdog_clear_instr_r
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire [9:0] idx = haddr[11:2];
    wire rd_now = hsel && htrans[1] && !hwrite && ce;
    // The command word reads zero, so it is left out of the readable set.
    wire mapped = idx == `TMR_COUNT_IDX || idx == `INT_CTRL_IDX || idx == `OPT_CFG_IDX
        || idx == `IRQ_STATUS_IDX || idx == `IRQ_MASK_IDX;
    reg rd_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= rd_now;
        end
    end
    sequence s_clr_addr;
        hsel && htrans[1] && hwrite && ce && idx == `WDT_CMD_IDX;
    endsequence
    sequence s_clr_wr;
        s_clr_addr ##1 (ce && hwdata[0]);
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("ready dropped");
    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_clear_pulse: assert property (s_clr_wr |-> ##[1:2] watchdog_clear_instr_r)
        else $error("no clear pulse");
    a_clear_single: assert property (watchdog_clear_instr_r |=> !watchdog_clear_instr_r)
        else $error("clear pulse too long");
    a_tick_cause: assert property (watchdog_timer_tick_r |-> $past(watchdog_timer_base_tick)
        || $past(watchdog_timer_base_tick, 2) || $past(watchdog_timer_base_tick, 3))
        else $error("tick without base tick");
    a_read_hold: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data moved");
    a_upper_zero: assert property (rd_now |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (rd_now && !mapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind timer0_shared_prescaler timer0_checker chk (.hclk, .hresetn, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hreadyout, .hresp, .hrdata, .watchdog_timer_base_tick,
    .watchdog_timer_tick_r, .watchdog_clear_instr_r);

//--- sim/ext_pulse_src.sv
// Pulse source standing in for whatever drives the external count pin.
`timescale 1ns/100ps
module ext_pulse_src (
    // Clock.
    input wire hclk,
    // Pin.
    output reg pin
);
    initial pin = 1'b0;
    // Under two cycles a level could slip between the two phase samples.
    task automatic pulses(input int n);
        repeat (n) begin
            pin <= 1'b1;
            repeat (6 + $urandom % 4) @(posedge hclk);
            pin <= 1'b0;
            repeat (6 + $urandom % 4) @(posedge hclk);
        end
        // Let the last edge clear the synchroniser and phase sampling before a read.
        repeat (4) @(posedge hclk);
    endtask
endmodule

//--- sim/timer0_shared_prescaler_tb.sv
// Self-checking bench for the timer block.
`timescale 1ns/100ps
`include "timer0_defs.vh"
module timer0_shared_prescaler_tb;
    reg hclk, hresetn, hsel, hwrite, base_tick, rd_dp;
    reg [1:0] htrans;
    reg [31:0] haddr, hwdata;
    wire hreadyout, hresp, tick, clr_pulse, irq, pin;
    wire [31:0] hrdata;
    int mismatches, tests_run, ticks, clrs;
    logic [31:0] expq[$];
    timer0_shared_prescaler dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .timer_ext_clock_pin(pin), .watchdog_timer_base_tick(base_tick),
        .watchdog_timer_tick_r(tick), .watchdog_clear_instr_r(clr_pulse), .irq(irq));
    ext_pulse_src src (.hclk(hclk), .pin(pin));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= `HTRANS_NONSEQ;
        haddr <= {20'h0, idx, 2'h0};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        expq.push_back(exp);
        xfer(1'b0, idx, 32'h0);
    endtask
    // The count write is followed by a wait that outlasts the two-tick increment pause.
    task automatic clr_cnt;
        xfer(1'b1, `TMR_COUNT_IDX, 32'h0);
        repeat (12) @(posedge hclk);
    endtask
    task automatic bticks(input int n);
        repeat (n) begin
            base_tick <= 1'b1;
            @(posedge hclk);
            base_tick <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask
    ////////////////////////////////////////////////////////////////
    // Read data is taken at the data-phase edge, where the master samples it.
    always @(posedge hclk) begin
        if (rd_dp && expq.size() > 0) chk(hrdata, expq.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite;
        if (tick === 1'b1) ticks++;
        if (clr_pulse === 1'b1) clrs++;
    end
    initial begin
        int r, t0;
        logic [31:0] v;
        {hresetn, hsel, hwrite, base_tick, rd_dp} = 5'h0;
        {htrans, haddr, hwdata} = 66'h0;
        {mismatches, tests_run, ticks, clrs} = 128'h0;
        r = $urandom(54);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b1, 10'h080, 32'h0);
        rd(`OPT_CFG_IDX, 32'hFF);
        rd(`TMR_COUNT_IDX, 32'h0);
        rd(10'h3FF, 32'h0);
        xfer(1'b1, `OPT_CFG_IDX, 32'h08);
        v = $urandom % 200;
        xfer(1'b1, `TMR_COUNT_IDX, v);
        repeat (4) rd(`TMR_COUNT_IDX, v);
        xfer(1'b1, `TMR_COUNT_IDX, 32'hFE);
        repeat (30) @(posedge hclk);
        rd(`INT_CTRL_IDX, 32'h04);
        rd(`IRQ_STATUS_IDX, 32'h01);
        xfer(1'b1, `IRQ_MASK_IDX, 32'h1);
        @(negedge hclk) chk({31'h0, irq}, 32'h1);
        @(posedge hclk) xfer(1'b1, `IRQ_STATUS_IDX, 32'h1);
        @(negedge hclk) chk({31'h0, irq}, 32'h0);
        @(posedge hclk) xfer(1'b1, `INT_CTRL_IDX, 32'h0);
        rd(`INT_CTRL_IDX, 32'h0);
        xfer(1'b1, `OPT_CFG_IDX, 32'h38);
        clr_cnt();
        src.pulses(5);
        rd(`TMR_COUNT_IDX, 32'h5);
        xfer(1'b1, `OPT_CFG_IDX, 32'h28);
        src.pulses(5);
        rd(`TMR_COUNT_IDX, 32'hA);
        for (r = 0; r < 8; r++) begin
            xfer(1'b1, `OPT_CFG_IDX, 32'h20 | r);
            clr_cnt();
            rd(`OPT_CFG_IDX, 32'h20 | r);
            src.pulses(4 << r);
            rd(`TMR_COUNT_IDX, 32'h2);
        end
        xfer(1'b1, `OPT_CFG_IDX, 32'h21);
        clr_cnt();
        src.pulses(1);
        clr_cnt();
        src.pulses(1);
        rd(`TMR_COUNT_IDX, 32'h0);
        t0 = ticks;
        bticks(3);
        chk_n(ticks - t0, 3);
        xfer(1'b1, `WDT_CMD_IDX, 32'h1);
        clr_cnt();
        for (r = 0; r < 8; r++) begin
            xfer(1'b1, `OPT_CFG_IDX, 32'h28 | r);
            xfer(1'b1, `WDT_CMD_IDX, 32'h1);
            repeat (4) @(posedge hclk);
            t0 = ticks;
            bticks(2 << r);
            chk_n(ticks - t0, 2);
        end
        chk_n(clrs, 9);
        rd(`WDT_CMD_IDX, 32'h0);
        rd(`IRQ_STATUS_IDX, 32'h2);
        repeat (4) @(posedge hclk);
        summarize();
    end
endmodule
